//--- logic/ldcr_pkg.sv
package ldcr_pkg;

  localparam int LDCR_NUM_CH = 2;

  // Register addresses
  localparam logic [7:0] LDCR_ADDR_RELAY = 8'h05;
  localparam logic [7:0] LDCR_ADDR_BIAS = 8'h08;
  localparam logic [7:0] LDCR_ADDR_TIMER_LO = 8'h1a;
  localparam logic [7:0] LDCR_ADDR_TIMER_HI = 8'h1b;
  localparam logic [7:0] LDCR_ADDR_REAL_COEF = 8'h21;
  localparam logic [7:0] LDCR_ADDR_THERM = 8'h48;

  // Reset values
  localparam logic [7:0] LDCR_RELAY_RST = 8'ha3;
  localparam logic [7:0] LDCR_BIAS_RST = 8'he0;
  localparam logic [7:0] LDCR_TIMER_BYTE_RST = 8'h00;
  localparam logic [3:0] LDCR_REAL_COEF_RST = 4'h0;
  localparam logic LDCR_THERM_SEL_RST = 1'b0;

  // Relay configuration fields
  localparam logic [1:0] LDCR_RELAY_FIXED_HI = 2'b10;
  localparam logic [1:0] LDCR_RELAY_FIXED_LO = 2'b00;
  localparam int LDCR_RELAY_BATTERY_SELECT_FLAG = 5;
  localparam int LDCR_RELAY_THIRD_RAIL_PRESENT = 4;
  localparam int LDCR_RELAY_RELAY_DRIVE_OUT_EN = 3;
  localparam int LDCR_RELAY_GPO = 2;

  // Bias control fields
  localparam int LDCR_BIAS_LOW_POWER_STANDBY = 7;
  localparam int LDCR_BIAS_AUDIO_SQUELCH = 6;
  localparam int LDCR_BIAS_FILTER_CAP_BYPASS = 5;
  localparam int LDCR_BIAS_EN = 4;
  localparam int LDCR_BIAS_ONHOOK_BIAS_LEVEL_HI = 3;
  localparam int LDCR_BIAS_ONHOOK_BIAS_LEVEL_LO = 2;
  localparam int LDCR_BIAS_ACTIVE_BIAS_LEVEL_HI = 1;
  localparam int LDCR_BIAS_ACTIVE_BIAS_LEVEL_LO = 0;

  // Thermal register fields
  localparam int LDCR_THERM_STAT = 7;
  localparam int LDCR_THERM_SEL = 6;
  localparam logic [5:0] LDCR_THERM_ZERO = 6'h00;
  localparam logic [3:0] LDCR_REAL_COEF_ZERO = 4'h0;
  localparam logic [7:0] LDCR_RDATA_NONE = 8'h00;

  // Silent timer unit, 1.25 us per count
  localparam int LDCR_CLK_PERIOD_NS = 40;
  localparam int LDCR_TIMER_LSB_NS = 1250;
  localparam int LDCR_TIMER_LSB_CYC_I = (LDCR_TIMER_LSB_NS / LDCR_CLK_PERIOD_NS) < 1 ? 1 :
                                        (LDCR_TIMER_LSB_NS / LDCR_CLK_PERIOD_NS);
  localparam logic [5:0] LDCR_TIMER_LSB_LAST = 6'(LDCR_TIMER_LSB_CYC_I - 1);
  localparam logic [5:0] LDCR_TIMER_CNT_ZERO = 6'h00;
  localparam logic [5:0] LDCR_TIMER_CNT_ONE = 6'h01;

  // Effective value of an override bit
  function automatic logic ldcr_pick(input logic manual, input logic written, input logic auto_val);
    ldcr_pick = manual ? written : auto_val;
  endfunction

endpackage

//--- logic/ldcr_if.sv
`timescale 1ns/1ns
interface ldcr_chan_if;
  logic wr_timer_lo;
  logic wr_timer_hi;
  logic wr_relay;
  logic wr_bias;
  logic prot_ok;
  logic [7:0] wdata;
  logic soft_rst;
  logic hook_change;
  logic speedup_event;
  logic auto_standby;
  logic auto_bias_en;
  logic auto_squelch;
  logic auto_cap_bypass;
  logic battery_select_pin;
  logic [7:0] relay_rd;
  logic [7:0] bias_rd;
  logic [15:0] timer;

  modport ctrl (output wr_timer_lo, wr_timer_hi, wr_relay, wr_bias, prot_ok, wdata, soft_rst,
                hook_change, speedup_event, auto_standby, auto_bias_en, auto_squelch,
                auto_cap_bypass, battery_select_pin,
                input relay_rd, bias_rd, timer);
  modport regs (input wr_timer_lo, wr_timer_hi, wr_relay, wr_bias, prot_ok, wdata, soft_rst,
                hook_change, speedup_event, auto_standby, auto_bias_en, auto_squelch,
                auto_cap_bypass, battery_select_pin,
                output relay_rd, bias_rd, timer);
endinterface

interface ldcr_shared_if;
  logic wr_therm;
  logic wr_coef;
  logic prot_ok;
  logic [7:0] wdata;
  logic shutdown;
  logic [7:0] therm_rd;
  logic [7:0] coef_rd;

  modport ctrl (output wr_therm, wr_coef, prot_ok, wdata, shutdown, input therm_rd, coef_rd);
  modport regs (input wr_therm, wr_coef, prot_ok, wdata, shutdown, output therm_rd, coef_rd);
endinterface

//--- logic/ldcr_channel_regs.sv
`timescale 1ns/1ns
module ldcr_channel_regs
  import ldcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  ldcr_chan_if.regs cif
);

  logic [15:0] timer_q;
  logic third_rail_present_q;
  logic relay_drive_out_en_q;
  logic gpo_q;
  logic [7:0] bias_q;
  logic man_standby_q;
  logic man_bias_en_q;
  logic man_squelch_q;
  logic man_cap_q;
  logic bias_wr;

  // Protected bits only land while the protection scheme allows it
  assign bias_wr = cif.wr_bias && cif.prot_ok;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= {LDCR_TIMER_BYTE_RST, LDCR_TIMER_BYTE_RST};
    end else if (cif.soft_rst) begin
      timer_q <= {LDCR_TIMER_BYTE_RST, LDCR_TIMER_BYTE_RST};
    end else begin
      if (cif.wr_timer_lo) begin
        timer_q[7:0] <= cif.wdata;
      end
      if (cif.wr_timer_hi) begin
        timer_q[15:8] <= cif.wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      third_rail_present_q <= LDCR_RELAY_RST[LDCR_RELAY_THIRD_RAIL_PRESENT];
      relay_drive_out_en_q <= LDCR_RELAY_RST[LDCR_RELAY_RELAY_DRIVE_OUT_EN];
      gpo_q <= LDCR_RELAY_RST[LDCR_RELAY_GPO];
    end else if (cif.soft_rst) begin
      third_rail_present_q <= LDCR_RELAY_RST[LDCR_RELAY_THIRD_RAIL_PRESENT];
      relay_drive_out_en_q <= LDCR_RELAY_RST[LDCR_RELAY_RELAY_DRIVE_OUT_EN];
      gpo_q <= LDCR_RELAY_RST[LDCR_RELAY_GPO];
    end else if (cif.wr_relay) begin
      third_rail_present_q <= cif.wdata[LDCR_RELAY_THIRD_RAIL_PRESENT];
      relay_drive_out_en_q <= cif.wdata[LDCR_RELAY_RELAY_DRIVE_OUT_EN];
      gpo_q <= cif.wdata[LDCR_RELAY_GPO];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bias_q <= LDCR_BIAS_RST;
    end else if (cif.soft_rst) begin
      bias_q <= LDCR_BIAS_RST;
    end else if (bias_wr) begin
      bias_q <= cif.wdata;
    end
  end

  // Flags start set so the reset value reads back until automatic control takes over;
  // a write in the same cycle as a release event wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      man_standby_q <= 1'b1;
      man_bias_en_q <= 1'b1;
    end else if (cif.soft_rst) begin
      man_standby_q <= 1'b1;
      man_bias_en_q <= 1'b1;
    end else if (bias_wr) begin
      man_standby_q <= 1'b1;
      man_bias_en_q <= 1'b1;
    end else if (cif.hook_change) begin
      man_standby_q <= 1'b0;
      man_bias_en_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      man_squelch_q <= 1'b1;
      man_cap_q <= 1'b1;
    end else if (cif.soft_rst) begin
      man_squelch_q <= 1'b1;
      man_cap_q <= 1'b1;
    end else if (bias_wr) begin
      man_squelch_q <= 1'b1;
      man_cap_q <= 1'b1;
    end else if (cif.speedup_event) begin
      man_squelch_q <= 1'b0;
      man_cap_q <= 1'b0;
    end
  end

  assign cif.timer = timer_q;
  assign cif.relay_rd = {LDCR_RELAY_FIXED_HI, cif.battery_select_pin, third_rail_present_q, relay_drive_out_en_q, gpo_q,
                         LDCR_RELAY_FIXED_LO};
  assign cif.bias_rd = {ldcr_pick(man_standby_q, bias_q[LDCR_BIAS_LOW_POWER_STANDBY], cif.auto_standby),
                        ldcr_pick(man_squelch_q, bias_q[LDCR_BIAS_AUDIO_SQUELCH], cif.auto_squelch),
                        ldcr_pick(man_cap_q, bias_q[LDCR_BIAS_FILTER_CAP_BYPASS], cif.auto_cap_bypass),
                        ldcr_pick(man_bias_en_q, bias_q[LDCR_BIAS_EN], cif.auto_bias_en),
                        bias_q[LDCR_BIAS_ONHOOK_BIAS_LEVEL_HI:LDCR_BIAS_ACTIVE_BIAS_LEVEL_LO]};

endmodule

//--- logic/ldcr_shared_regs.sv
`timescale 1ns/1ns
module ldcr_shared_regs
  import ldcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  ldcr_shared_if.regs sif
);

  logic therm_sel_q;
  logic [3:0] coef_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      therm_sel_q <= LDCR_THERM_SEL_RST;
    end else if (sif.wr_therm && sif.prot_ok) begin
      therm_sel_q <= sif.wdata[LDCR_THERM_SEL];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      coef_q <= LDCR_REAL_COEF_RST;
    end else if (sif.wr_coef) begin
      coef_q <= sif.wdata[3:0];
    end
  end

  // Status bit is live, never stored
  assign sif.therm_rd = {sif.shutdown, therm_sel_q, LDCR_THERM_ZERO};
  assign sif.coef_rd = {LDCR_REAL_COEF_ZERO, coef_q};

endmodule

//--- logic/line_driver_config_regs.sv
`timescale 1ns/1ns
module line_driver_config_regs
  import ldcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_chan,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic prot_unlock,
  input wire logic [1:0] soft_reset,
  input wire logic [1:0] hook_change,
  input wire logic [1:0] speedup_event,
  input wire logic [1:0] auto_standby,
  input wire logic [1:0] auto_bias_en,
  input wire logic [1:0] auto_squelch,
  input wire logic [1:0] auto_cap_bypass,
  input wire logic [1:0] battery_select_pin,
  input wire logic [1:0] ring_cadence,
  input wire logic power_stage_shutdown,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  output logic [1:0] relay_drive_pin_q,
  output logic [1:0] general_out_pin_q,
  output logic [1:0] low_power_standby_q,
  output logic [1:0] audio_squelch_q,
  output logic [1:0] filter_cap_bypass_q,
  output logic [1:0] line_bias_enable_q,
  output logic [1:0][1:0] onhook_bias_level_q,
  output logic [1:0][1:0] active_bias_level_q,
  output logic [1:0][15:0] ring_silent_timer_q,
  output logic timer_lsb_tick_q,
  output logic power_sense_diode_q,
  output logic [3:0] real_impedance_value_q
);

  ldcr_chan_if cif[LDCR_NUM_CH]();
  ldcr_shared_if sif();

  logic [7:0] relay_rd_w [LDCR_NUM_CH];
  logic [7:0] bias_rd_w [LDCR_NUM_CH];
  logic [15:0] timer_w [LDCR_NUM_CH];
  logic [7:0] rdata_d;
  logic [5:0] tick_cnt_q;

  genvar g;
  generate
    for (g = 0; g < LDCR_NUM_CH; g++) begin : gen_ch
      // Each channel decodes only when addressed
      logic sel;
      assign sel = reg_wr && (reg_chan == 1'(g));
      assign cif[g].wr_timer_lo = sel && (reg_addr == LDCR_ADDR_TIMER_LO);
      assign cif[g].wr_timer_hi = sel && (reg_addr == LDCR_ADDR_TIMER_HI);
      assign cif[g].wr_relay = sel && (reg_addr == LDCR_ADDR_RELAY);
      assign cif[g].wr_bias = sel && (reg_addr == LDCR_ADDR_BIAS);
      assign cif[g].prot_ok = prot_unlock;
      assign cif[g].wdata = reg_wdata;
      assign cif[g].soft_rst = soft_reset[g];
      assign cif[g].hook_change = hook_change[g];
      assign cif[g].speedup_event = speedup_event[g];
      assign cif[g].auto_standby = auto_standby[g];
      assign cif[g].auto_bias_en = auto_bias_en[g];
      assign cif[g].auto_squelch = auto_squelch[g];
      assign cif[g].auto_cap_bypass = auto_cap_bypass[g];
      assign cif[g].battery_select_pin = battery_select_pin[g];
      assign relay_rd_w[g] = cif[g].relay_rd;
      assign bias_rd_w[g] = cif[g].bias_rd;
      assign timer_w[g] = cif[g].timer;

      ldcr_channel_regs u_chan (
        .clock(clock),
        .rst_n(rst_n),
        .cif(cif[g])
      );
    end
  endgenerate

  // Shared registers ignore the channel select
  assign sif.wr_therm = reg_wr && (reg_addr == LDCR_ADDR_THERM);
  assign sif.wr_coef = reg_wr && (reg_addr == LDCR_ADDR_REAL_COEF);
  assign sif.prot_ok = prot_unlock;
  assign sif.wdata = reg_wdata;
  assign sif.shutdown = power_stage_shutdown;

  ldcr_shared_regs u_shared (
    .clock(clock),
    .rst_n(rst_n),
    .sif(sif)
  );

  always_comb begin
    unique case (reg_addr)
      LDCR_ADDR_RELAY: rdata_d = relay_rd_w[reg_chan];
      LDCR_ADDR_BIAS: rdata_d = bias_rd_w[reg_chan];
      LDCR_ADDR_TIMER_LO: rdata_d = timer_w[reg_chan][7:0];
      LDCR_ADDR_TIMER_HI: rdata_d = timer_w[reg_chan][15:8];
      LDCR_ADDR_REAL_COEF: rdata_d = sif.coef_rd;
      LDCR_ADDR_THERM: rdata_d = sif.therm_rd;
      default: rdata_d = LDCR_RDATA_NONE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= LDCR_RDATA_NONE;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

  // Pin drive follows the register bits, one clock late
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      relay_drive_pin_q <= 2'b00;
      general_out_pin_q <= 2'b00;
    end else begin
      for (int i = 0; i < LDCR_NUM_CH; i++) begin
        // With a third rail the general output follows the ringing cadence, and the relay drive pin does too while its enable bit is set
        relay_drive_pin_q[i] <= relay_rd_w[i][LDCR_RELAY_RELAY_DRIVE_OUT_EN] &&
                                (relay_rd_w[i][LDCR_RELAY_THIRD_RAIL_PRESENT] ? ring_cadence[i] : 1'b1);
        general_out_pin_q[i] <= relay_rd_w[i][LDCR_RELAY_THIRD_RAIL_PRESENT] ? ring_cadence[i]
                                                                : relay_rd_w[i][LDCR_RELAY_GPO];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_power_standby_q <= 2'b00;
      audio_squelch_q <= 2'b00;
      filter_cap_bypass_q <= 2'b00;
      line_bias_enable_q <= 2'b00;
      onhook_bias_level_q <= '0;
      active_bias_level_q <= '0;
      ring_silent_timer_q <= '0;
    end else begin
      for (int i = 0; i < LDCR_NUM_CH; i++) begin
        low_power_standby_q[i] <= bias_rd_w[i][LDCR_BIAS_LOW_POWER_STANDBY];
        audio_squelch_q[i] <= bias_rd_w[i][LDCR_BIAS_AUDIO_SQUELCH];
        filter_cap_bypass_q[i] <= bias_rd_w[i][LDCR_BIAS_FILTER_CAP_BYPASS];
        line_bias_enable_q[i] <= bias_rd_w[i][LDCR_BIAS_EN];
        onhook_bias_level_q[i] <= bias_rd_w[i][LDCR_BIAS_ONHOOK_BIAS_LEVEL_HI:LDCR_BIAS_ONHOOK_BIAS_LEVEL_LO];
        active_bias_level_q[i] <= bias_rd_w[i][LDCR_BIAS_ACTIVE_BIAS_LEVEL_HI:LDCR_BIAS_ACTIVE_BIAS_LEVEL_LO];
        ring_silent_timer_q[i] <= timer_w[i];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_sense_diode_q <= LDCR_THERM_SEL_RST;
      real_impedance_value_q <= LDCR_REAL_COEF_RST;
    end else begin
      power_sense_diode_q <= sif.therm_rd[LDCR_THERM_SEL];
      real_impedance_value_q <= sif.coef_rd[3:0];
    end
  end

  // Timer unit is 31 clocks, 1.24 us; the fractional cycle cannot be met at 25 MHz
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= LDCR_TIMER_CNT_ZERO;
      timer_lsb_tick_q <= 1'b0;
    end else begin
      timer_lsb_tick_q <= (tick_cnt_q == LDCR_TIMER_LSB_LAST);
      if (tick_cnt_q == LDCR_TIMER_LSB_LAST) begin
        tick_cnt_q <= LDCR_TIMER_CNT_ZERO;
      end else begin
        tick_cnt_q <= tick_cnt_q + LDCR_TIMER_CNT_ONE;
      end
    end
  end

endmodule

//--- test/ldcr_checker_sva.sv
`timescale 1ns/1ns
module ldcr_checker
  import ldcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_chan,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic prot_unlock,
  input wire logic [1:0] soft_reset,
  input wire logic [1:0] battery_select_pin,
  input wire logic power_stage_shutdown,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  input wire logic [1:0] relay_drive_pin_q,
  input wire logic [1:0] general_out_pin_q,
  input wire logic [1:0][1:0] onhook_bias_level_q,
  input wire logic [1:0][1:0] active_bias_level_q,
  input wire logic timer_lsb_tick_q,
  input wire logic [3:0] real_impedance_value_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic mapped;
  assign mapped = reg_addr inside {8'h05, 8'h08, 8'h1a, 8'h1b, 8'h21, 8'h48};
  logic wr_a;
  assign wr_a = reg_wr && !reg_chan && !soft_reset[0];

  AST_RVALID_PULSE: assert property (reg_rd |=> reg_rvalid_q) else $error("read without valid");
  AST_RVALID_CAUSE: assert property (reg_rvalid_q |-> $past(reg_rd)) else $error("valid without read");
  AST_RELAY_READ: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata_q[7:6] == 2'b10 &&
    reg_rdata_q[1:0] == 2'b00 && reg_rdata_q[5] == $past(battery_select_pin[reg_chan])) else $error("relay read bad");
  AST_THERM_READ: assert property (reg_rd && reg_addr == 8'h48 |=> reg_rdata_q[5:0] == 6'h00 &&
    reg_rdata_q[7] == $past(power_stage_shutdown)) else $error("thermal read bad");
  AST_COEF_READ: assert property (reg_rd && reg_addr == 8'h21 |=>
    reg_rdata_q == {4'h0, $past(real_impedance_value_q)}) else $error("coefficient read bad");
  AST_UNMAPPED: assert property (reg_rd && !mapped |=> reg_rdata_q == 8'h00) else $error("unmapped read nonzero");
  AST_TICK_PERIOD: assert property (timer_lsb_tick_q |-> ##31 timer_lsb_tick_q) else $error("tick period bad");
  AST_RELAY_PINS: assert property (wr_a && reg_addr == 8'h05 && !reg_wdata[4] ##1 !reg_wr && !soft_reset[0]
    |=> relay_drive_pin_q[0] == $past(reg_wdata[3], 2) && general_out_pin_q[0] == $past(reg_wdata[2], 2))
    else $error("relay pins bad");
  AST_BIAS_WRITE: assert property (wr_a && reg_addr == 8'h08 && prot_unlock ##1 !reg_wr && !soft_reset[0]
    |=> {onhook_bias_level_q[0], active_bias_level_q[0]} == $past(reg_wdata[3:0], 2)) else $error("bias write bad");
  AST_BIAS_LOCKED: assert property (wr_a && reg_addr == 8'h08 && !prot_unlock ##1 !reg_wr && !soft_reset[0]
    |=> $stable(onhook_bias_level_q[0]) && $stable(active_bias_level_q[0])) else $error("locked bias changed");
  AST_SOFT_RESET: assert property (soft_reset[0] ##1 !reg_wr |=> relay_drive_pin_q[0] == 1'b0 &&
    onhook_bias_level_q[0] == 2'b00 && active_bias_level_q[0] == 2'b00) else $error("soft reset defaults bad");
endmodule

//--- test/line_driver_config_regs_bench.sv
`timescale 1ns/1ns
module line_driver_config_regs_bench import ldcr_pkg::*;;
  logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_chan = 1'b0;
  logic prot_unlock = 1'b0, power_stage_shutdown = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [1:0] soft_reset = '0, hook_change = '0, speedup_event = '0, auto_standby = '0, auto_bias_en = '0;
  logic [1:0] auto_squelch = '0, auto_cap_bypass = '0, battery_select_pin = 2'h1, ring_cadence = '0;
  logic [7:0] reg_rdata_q;
  logic reg_rvalid_q, timer_lsb_tick_q, power_sense_diode_q;
  logic [1:0] relay_drive_pin_q, general_out_pin_q, low_power_standby_q, audio_squelch_q;
  logic [1:0] filter_cap_bypass_q, line_bias_enable_q;
  logic [1:0][1:0] onhook_bias_level_q, active_bias_level_q;
  logic [1:0][15:0] ring_silent_timer_q;
  logic [3:0] real_impedance_value_q;
  logic [7:0] m_relay [2], m_bias [2], m_tlo [2], m_thi [2];
  logic [7:0] addrs [8] = '{8'h05, 8'h08, 8'h1a, 8'h1b, 8'h21, 8'h48, 8'h30, 8'hff};
  logic [3:0] m_coef = 4'h0;
  logic m_sel = 1'b0, ch;
  logic [7:0] a;
  int err_total = 0, tests_run = 0, seed = 22704, cyc = 0, n;

  line_driver_config_regs dut (.clock, .rst_n, .reg_wr, .reg_rd, .reg_chan, .reg_addr, .reg_wdata, .prot_unlock,
    .soft_reset, .hook_change, .speedup_event, .auto_standby, .auto_bias_en, .auto_squelch, .auto_cap_bypass,
    .battery_select_pin, .ring_cadence, .power_stage_shutdown, .reg_rdata_q, .reg_rvalid_q, .relay_drive_pin_q,
    .general_out_pin_q, .low_power_standby_q, .audio_squelch_q, .filter_cap_bypass_q, .line_bias_enable_q,
    .onhook_bias_level_q, .active_bias_level_q, .ring_silent_timer_q, .timer_lsb_tick_q, .power_sense_diode_q,
    .real_impedance_value_q);

  always #20 clock = ~clock;

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Ceiling well above the roughly 1400 cycles the sequence needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected readback from the bench's own copy of the registers
  function automatic logic [7:0] exp_of(input logic c, input logic [7:0] ad);
    case (ad)
      8'h05: return {2'b10, battery_select_pin[c], m_relay[c][4:2], 2'b00};
      8'h08: return m_bias[c];
      8'h1a: return m_tlo[c];
      8'h1b: return m_thi[c];
      8'h21: return {4'h0, m_coef};
      8'h48: return {power_stage_shutdown, m_sel, 6'h00};
      default: return 8'h00;
    endcase
  endfunction

  task automatic mreset(input logic c);
    m_relay[c] = 8'ha3;
    m_bias[c] = 8'he0;
    m_tlo[c] = 8'h00;
    m_thi[c] = 8'h00;
  endtask

  task automatic wr(input logic c, input logic [7:0] ad, input logic [7:0] d, input logic p);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_chan <= c;
    reg_addr <= ad;
    reg_wdata <= d;
    prot_unlock <= p;
    @(posedge clock);
    reg_wr <= 1'b0;
    case (ad)
      8'h05: m_relay[c] = d;
      8'h08: if (p) m_bias[c] = d;
      8'h1a: m_tlo[c] = d;
      8'h1b: m_thi[c] = d;
      8'h21: m_coef = d[3:0];
      8'h48: if (p) m_sel = d[6];
      default: ;
    endcase
  endtask

  task automatic rd(input logic c, input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_chan <= c;
    reg_addr <= ad;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rvalid_q, 1'b1);
    chk(reg_rdata_q, exp);
  endtask

  task automatic pulse(input int which);
    @(posedge clock);
    if (which == 0) hook_change <= 2'h1;
    else speedup_event <= 2'h1;
    @(posedge clock);
    hook_change <= '0;
    speedup_event <= '0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  initial begin
    mreset(1'b0);
    mreset(1'b1);
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    for (int c = 0; c < 2; c++)
      for (int j = 0; j < 8; j++) rd(1'(c), addrs[j], exp_of(1'(c), addrs[j]));
    for (int i = 0; i < 250; i++) begin
      ch = 1'($random(seed));
      a = addrs[3'($random(seed))];
      @(posedge clock);
      battery_select_pin <= 2'($random(seed));
      ring_cadence <= 2'($random(seed));
      power_stage_shutdown <= 1'($random(seed));
      auto_standby <= 2'($random(seed));
      auto_squelch <= 2'($random(seed));
      if (($random(seed) & 15) == 0) begin
        soft_reset[ch] <= 1'b1;
        @(posedge clock);
        soft_reset <= '0;
        mreset(ch);
      end
      // Random data hits reserved and read-only bits; random unlock exercises protection
      wr(ch, a, 8'($random(seed)), 1'($random(seed)));
      rd(ch, a, exp_of(ch, a));
      chk(real_impedance_value_q, m_coef);
      chk(power_sense_diode_q, m_sel);
      for (int c = 0; c < 2; c++) begin
        chk(ring_silent_timer_q[c], {m_thi[c], m_tlo[c]});
        chk(relay_drive_pin_q[c], m_relay[c][3] & (m_relay[c][4] ? ring_cadence[c] : 1'b1));
        chk(general_out_pin_q[c], m_relay[c][4] ? ring_cadence[c] : m_relay[c][2]);
        chk({onhook_bias_level_q[c], active_bias_level_q[c]}, m_bias[c][3:0]);
      end
    end
    @(posedge clock);
    auto_standby <= 2'h0;
    auto_bias_en <= 2'h3;
    auto_squelch <= 2'h0;
    auto_cap_bypass <= 2'h3;
    wr(1'b0, 8'h08, 8'hc5, 1'b1);
    rd(1'b0, 8'h08, 8'hc5);
    pulse(0);
    chk({low_power_standby_q[0], line_bias_enable_q[0], audio_squelch_q[0], filter_cap_bypass_q[0]}, 4'h6);
    rd(1'b0, 8'h08, 8'h55);
    pulse(1);
    chk({audio_squelch_q[0], filter_cap_bypass_q[0]}, 2'h1);
    rd(1'b0, 8'h08, 8'h35);
    rd(1'b1, 8'h08, m_bias[1]);
    wr(1'b0, 8'h08, 8'hff, 1'b0);
    rd(1'b0, 8'h08, 8'h35);
    n = 0;
    // Look after the edge so the tick launched by it is settled
    do begin
      @(posedge clock);
      #1;
    end while (timer_lsb_tick_q !== 1'b1 && ++n < 100);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (timer_lsb_tick_q !== 1'b1 && n < 100);
    chk(16'(n), 16'h001f);
    final_report();
  end
endmodule

bind line_driver_config_regs ldcr_checker chk_i (.clock, .rst_n, .reg_wr, .reg_rd, .reg_chan, .reg_addr,
  .reg_wdata, .prot_unlock, .soft_reset, .battery_select_pin, .power_stage_shutdown, .reg_rdata_q, .reg_rvalid_q,
  .relay_drive_pin_q, .general_out_pin_q, .onhook_bias_level_q, .active_bias_level_q, .timer_lsb_tick_q,
  .real_impedance_value_q);
